// file: tb/serial_peer.sv
`timescale 1ns/1ns
// external link master: makes the link clock, drives data in and the two-wire data line
module serial_peer (
    output logic sck,
    output logic sdi,
    output logic sda
);
    // clock idles low and stands still between frames; data line released
    initial begin
        sck = 1'b0;
        sdi = 1'b1;
        sda = 1'b1;
    end
    // n link-clock edges, 160 ns period, far below a quarter of clk
    task automatic edges(input int n);
        repeat (n) begin
            #80;
            sck <= ~sck;
        end
        #80;
    endtask
    // moves the two-wire data line while the clock stands still
    task automatic data_to(input logic v);
        #80;
        sda <= v;
        #80;
    endtask
endmodule

// file: tb/serial_shift_unit_test.sv
`timescale 1ns/1ns
module serial_shift_unit_test;
    import serial_unit_pkg::*;
    logic clk, nrst, cyc, stb, we, tmatch;
    logic [9:0] adr;
    logic [31:0] wdat, rdat;
    logic ack, sck_o, sck_oe_n, do_o, do_oe_n, s_irq, o_irq, wake;
    logic [1:0] sleep;
    logic peer_sck, peer_sdi, peer_sda, sck_line, do_line;
    logic [7:0] rd;
    int n_fail, total_checks;

    // wired-and lines: either side pulling low wins, released lines float high
    assign sck_line = peer_sck && (sck_oe_n || sck_o);
    assign do_line = peer_sda && (do_oe_n || do_o);

    serial_peer u_peer (.sck(peer_sck), .sdi(peer_sdi), .sda(peer_sda));

    serial_shift_unit u_dut (
        .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .timer_match(tmatch), .sleep_mode(sleep),
        .data_in_pin(peer_sdi), .serial_clock_pin_i(sck_line),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n(sck_oe_n),
        .data_out_pin_i(do_line), .data_out_pin_o(do_o),
        .data_out_pin_oe_n(do_oe_n), .start_irq(s_irq),
        .overflow_irq(o_irq), .wake_request(wake)
    );

    // 100 MHz system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // byte compare
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask

    // single-bit compare
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask

    // one classic cycle; waits for ack, the watchdog bounds a hang
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    // read and compare under a mask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk8(rd & m, e);
    endtask

    // register reset values and an unmapped place
    task automatic t_reset;
        rchk(CTRL_INDEX, 8'hFF, CTRL_RESET);
        rchk(STAT_INDEX, 8'hEF, STAT_RESET);
        rchk(STAT_INDEX, 8'h10, 8'h10);
        rchk(DATA_INDEX, 8'hFF, DATA_RESET);
        wr(8'h20, 8'hFF);
        rchk(8'h20, 8'hFF, 8'h00);
    endtask

    // software strobes and timer match as clock sources
    task automatic t_soft;
        wr(DATA_INDEX, 8'h81);
        wr(CTRL_INDEX, 8'h02);
        rchk(DATA_INDEX, 8'hFF, 8'h03);
        rchk(STAT_INDEX, 8'h0F, 8'h01);
        rchk(CTRL_INDEX, 8'hFF, 8'h00);
        wr(CTRL_INDEX, 8'h01);
        rchk(STAT_INDEX, 8'h0F, 8'h02);
        wr(CTRL_INDEX, 8'h04);
        @(posedge clk);
        tmatch <= 1'b1;
        @(posedge clk);
        tmatch <= 1'b0;
        rchk(STAT_INDEX, 8'h0F, 8'h03);
        wr(STAT_INDEX, 8'h0A);
        rchk(STAT_INDEX, 8'h0F, 8'h0A);
    endtask

    // external edges with no wire mode: both edges count, F overflows
    task automatic t_ext;
        wr(CTRL_INDEX, 8'h08);
        wr(STAT_INDEX, 8'hCF);
        u_peer.edges(1);
        rchk(STAT_INDEX, 8'hEF, 8'hC0);
        u_peer.edges(1);
        rchk(STAT_INDEX, 8'hEF, 8'hC1);
        wr(STAT_INDEX, 8'hC0);
        rchk(STAT_INDEX, 8'hEF, 8'h00);
        wr(STAT_INDEX, 8'h0F);
        u_peer.edges(1);
        rchk(STAT_INDEX, 8'hEF, 8'hC0);
        rchk(BUF_INDEX, 8'hFF, 8'h1F);
        rchk(STAT_INDEX, 8'hEF, 8'h80);
        wr(STAT_INDEX, 8'h80);
        rchk(STAT_INDEX, 8'hEF, 8'h00);
    endtask

    // interrupt requests and wake-up by sleep mode
    task automatic t_irq;
        wr(PORT_INDEX, 8'h10);
        wr(STAT_INDEX, 8'h0F);
        wr(CTRL_INDEX, 8'h48);
        u_peer.edges(1);
        chk1(o_irq, 1'b1);
        chk1(s_irq, 1'b0);
        chk1(wake, 1'b1);
        @(posedge clk);
        sleep <= 2'h2;
        @(posedge clk);
        #1;
        chk1(wake, 1'b0);
        wr(CTRL_INDEX, 8'hC8);
        #1;
        chk1(s_irq, 1'b1);
        chk1(wake, 1'b1);
        wr(STAT_INDEX, 8'hC0);
        #1;
        chk1(o_irq, 1'b0);
        chk1(s_irq, 1'b0);
        @(posedge clk);
        sleep <= 2'h1;
    endtask

    // three-wire data out follows the MSB through an open latch
    task automatic t_dout;
        wr(PORT_INDEX, 8'h04);
        wr(CTRL_INDEX, 8'h10);
        wr(DATA_INDEX, 8'h80);
        #1;
        chk1(do_o, 1'b1);
        chk1(do_oe_n, 1'b0);
        rchk(STAT_INDEX, 8'h10, 8'h00);
        wr(DATA_INDEX, 8'h7F);
        #1;
        chk1(do_o, 1'b0);
        wr(PORT_INDEX, 8'h00);
        #1;
        chk1(do_oe_n, 1'b1);
    endtask

    // two-wire slave: start and stop detection, clock holds, open-drain data
    task automatic t_twi;
        u_peer.edges(1);
        wr(DATA_INDEX, 8'hFF);
        wr(STAT_INDEX, 8'hE0);
        wr(CTRL_INDEX, 8'h28);
        wr(PORT_INDEX, 8'h0F);
        chk1(sck_oe_n, 1'b1);
        chk1(do_oe_n, 1'b1);
        u_peer.data_to(1'b0);
        rchk(STAT_INDEX, 8'hE0, 8'h80);
        u_peer.edges(1);
        chk1(sck_oe_n, 1'b0);
        chk1(sck_o, 1'b0);
        wr(STAT_INDEX, 8'h80);
        #1;
        chk1(sck_oe_n, 1'b1);
        u_peer.edges(1);
        u_peer.data_to(1'b1);
        rchk(STAT_INDEX, 8'hEF, 8'h21);
        wr(CTRL_INDEX, 8'h38);
        wr(STAT_INDEX, 8'h2F);
        u_peer.edges(1);
        chk1(sck_oe_n, 1'b0);
        wr(STAT_INDEX, 8'h40);
        #1;
        chk1(sck_oe_n, 1'b1);
        wr(DATA_INDEX, 8'h00);
        #1;
        chk1(do_oe_n, 1'b0);
        chk1(do_o, 1'b0);
    endtask

    // verdict and end of run
    task automatic wrap_up;
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // main sequence, reset held ten cycles
    initial begin
        nrst = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        tmatch = 1'b0;
        adr = 10'h000;
        wdat = 32'h00000000;
        sleep = 2'h1;
        n_fail = 0;
        total_checks = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_soft();
        t_ext();
        t_irq();
        t_dout();
        t_twi();
        wrap_up();
    end

    // watchdog well past the few microseconds the tests need
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule

// file: verilog/pin_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for the link pins
module pin_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] async_in,
    output logic [2:0] sync_out
);
    logic [2:0] meta_reg; // first stage, read only by the second
    logic [2:0] sync_reg;

    // both stages reset to idle-high lines
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 3'h7;
            sync_reg <= 3'h7;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// file: verilog/serial_shift_unit.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module serial_shift_unit (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_match,
    input wire logic [1:0] sleep_mode,
    input wire logic data_in_pin,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n,
    input wire logic data_out_pin_i,
    output logic data_out_pin_o,
    output logic data_out_pin_oe_n,
    output logic start_irq,
    output logic overflow_irq,
    output logic wake_request
);
    import serial_unit_pkg::*;

    // sleep encodings seen by the wake logic
    localparam logic [1:0] SLEEP_IDLE = 2'h1;

    logic [2:0] pins_sync; // {sda, scl, din} after two flops
    logic sda_s, scl_s, din_s;
    logic scl_d_reg, scl_d_next; // last sampled clock level
    logic sda_d_reg, sda_d_next;

    // inputs are synchronised regardless of wire mode
    pin_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({data_out_pin_i, serial_clock_pin_i, data_in_pin}),
        .sync_out(pins_sync)
    );
    assign din_s = pins_sync[0];
    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[2];

    // state
    logic [7:0] ctrl_reg, ctrl_next; // toggle strobe bit never stored; shift strobe bit kept, reads as zero
    logic [7:0] data_reg, data_next;
    logic [7:0] buf_reg, buf_next;
    logic [3:0] cnt_reg, cnt_next;
    logic start_reg, start_next;
    logic ovf_reg, ovf_next;
    logic stop_reg, stop_next;
    logic latch_reg, latch_next; // output latch
    logic [4:0] port_reg, port_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic hold_start_reg, hold_start_next; // start detector clock hold

    logic [1:0] wm, cs;
    logic two_wire, ext_src;
    logic scl_rise, scl_fall, scl_edge;
    logic start_cond, stop_cond;
    logic req, wr, rd;
    logic [7:0] idx;
    logic wr_ctrl, wr_stat, wr_data, wr_port, rd_buf;
    logic shift_stb, toggle_stb;
    logic shift_clk, cnt_clk;
    logic wrap;

    assign wm = ctrl_reg[WM_HI_BIT:WM_LO_BIT];
    assign cs = ctrl_reg[CS_HI_BIT:CS_LO_BIT];
    assign two_wire = wm[1];
    assign ext_src = cs[1];

    // edge detection on synchronised pins against the level sampled one clk earlier
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign scl_edge = scl_rise || scl_fall;
    assign start_cond = two_wire && scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_cond = two_wire && scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // bus decode; byte lane 0 carries the 8-bit register
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign idx = wb_adr_i[9:2];
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign wr_ctrl = wr && (idx == CTRL_INDEX);
    assign wr_stat = wr && (idx == STAT_INDEX);
    assign wr_data = wr && (idx == DATA_INDEX);
    assign wr_port = wr && (idx == PORT_INDEX);
    assign rd_buf = rd && (idx == BUF_INDEX);
    assign shift_stb = wr_ctrl && wb_dat_i[SHIFT_STB_BIT];
    assign toggle_stb = wr_ctrl && wb_dat_i[TOGGLE_STB_BIT];

    // increment with wrap detect; the carry marks fifteen to zero
    function automatic logic [4:0] inc4(input logic [3:0] v);
        inc4 = {1'b0, v} + 5'h01;
    endfunction

    // clock selection, from the control value in effect this cycle
    always_comb begin
        shift_clk = 1'b0;
        cnt_clk = 1'b0;
        unique case (cs)
            CS_SOFT: begin
                shift_clk = shift_stb;
                cnt_clk = shift_stb || toggle_stb;
            end
            CS_TIMER: begin
                shift_clk = timer_match;
                cnt_clk = timer_match || toggle_stb;
            end
            CS_EXT_POS: begin
                shift_clk = scl_rise;
                cnt_clk = scl_edge || (toggle_stb && ctrl_reg[SHIFT_STB_BIT]);
            end
            CS_EXT_NEG: begin
                shift_clk = scl_fall;
                cnt_clk = scl_edge || (toggle_stb && ctrl_reg[SHIFT_STB_BIT]);
            end
        endcase
    end

    logic [4:0] cnt_inc; // counter plus one, carry in the top bit
    assign cnt_inc = inc4(cnt_reg);
    assign wrap = cnt_clk && cnt_inc[4];

    // next-state for the shift path, counter and flags
    always_comb begin
        data_next = data_reg;
        cnt_next = cnt_reg;
        start_next = start_reg;
        ovf_next = ovf_reg;
        stop_next = stop_reg;
        buf_next = buf_reg;
        hold_start_next = hold_start_reg;
        // shift path
        if (wr_data) begin
            data_next = wb_dat_i[7:0];
        end else if (shift_clk) begin
            data_next = {data_reg[6:0], din_s};
        end
        // counter: cpu write takes the place of a count
        if (wr_stat) begin
            cnt_next = wb_dat_i[3:0];
        end else if (cnt_clk) begin
            cnt_next = cnt_inc[3:0];
        end
        if (wrap) begin
            buf_next = {data_reg[6:0], din_s};
        end
        // write-one clears; hardware set wins
        if (wr_stat && wb_dat_i[START_FLAG_BIT]) begin
            start_next = 1'b0;
            hold_start_next = 1'b0;
        end
        if (two_wire && start_cond) begin
            start_next = 1'b1;
        end else if (!two_wire && ext_src && !ctrl_reg[SHIFT_STB_BIT] && scl_edge) begin
            start_next = 1'b1;
        end
        // hold is armed after master pulls clock low following start
        if (two_wire && start_reg && scl_fall) begin
            hold_start_next = 1'b1;
        end
        if (!two_wire) begin
            hold_start_next = 1'b0;
        end
        if ((wr_stat && wb_dat_i[OVF_FLAG_BIT]) || rd_buf) begin
            ovf_next = 1'b0;
        end
        if (wrap) begin
            ovf_next = 1'b1;
        end
        if (wr_stat && wb_dat_i[STOP_FLAG_BIT]) begin
            stop_next = 1'b0;
        end
        if (stop_cond) begin
            stop_next = 1'b1;
        end
    end

    // output latch: open first half of external cycle, always otherwise
    always_comb begin
        latch_next = latch_reg;
        if (!ext_src) begin
            latch_next = data_next[7];
        end else if ((cs == CS_EXT_POS) ? !scl_s : scl_s) begin
            latch_next = data_next[7];
        end
    end

    // bus control, port and read data
    always_comb begin
        ctrl_next = ctrl_reg;
        port_next = port_reg;
        ack_next = req;
        rdat_next = 32'h0000_0000;
        if (wr_ctrl) begin
            ctrl_next = {wb_dat_i[7:2], wb_dat_i[1], 1'b0};
        end else begin
            ctrl_next[SHIFT_STB_BIT] = ctrl_reg[SHIFT_STB_BIT];
        end
        if (wr_port) begin
            port_next = wb_dat_i[4:0];
        end
        if (rd) begin
            unique case (idx)
                CTRL_INDEX: rdat_next = {24'h0, ctrl_reg[7:2], 2'h0};
                STAT_INDEX: rdat_next = {24'h0, start_reg, ovf_reg, stop_reg,
                    (latch_reg != sda_s), cnt_reg};
                DATA_INDEX: rdat_next = {24'h0, data_reg};
                BUF_INDEX: rdat_next = {24'h0, buf_reg};
                PORT_INDEX: rdat_next = {27'h0, port_reg};
                default: rdat_next = 32'h0000_0000;
            endcase
        end
        scl_d_next = scl_s;
        sda_d_next = sda_s;
    end

    // registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RESET;
            data_reg <= DATA_RESET;
            buf_reg <= DATA_RESET;
            cnt_reg <= CNT_RESET;
            start_reg <= 1'b0;
            ovf_reg <= 1'b0;
            stop_reg <= 1'b0;
            latch_reg <= 1'b0;
            port_reg <= 5'h00;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            hold_start_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            data_reg <= data_next;
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
            start_reg <= start_next;
            ovf_reg <= ovf_next;
            stop_reg <= stop_next;
            latch_reg <= latch_next;
            port_reg <= port_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            hold_start_reg <= hold_start_next;
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // pin drive; enables active low, outputs dead in mode off
    logic clk_low, data_low;
    assign clk_low = !port_reg[PORT_CLK_BIT] || hold_start_reg
        || (wm == WM_TWO_HOLD && ovf_reg);
    assign data_low = !latch_reg || !port_reg[PORT_DATA_BIT];
    always_comb begin
        serial_clock_pin_o = 1'b0;
        serial_clock_pin_oe_n = 1'b1;
        data_out_pin_o = 1'b0;
        data_out_pin_oe_n = 1'b1;
        unique case (wm)
            WM_OFF: begin
                data_out_pin_oe_n = 1'b1; // outputs only are disabled
            end
            WM_THREE: begin
                data_out_pin_o = latch_reg;
                data_out_pin_oe_n = !port_reg[DIR_DATA_BIT];
                serial_clock_pin_o = port_reg[PORT_CLK_BIT];
                serial_clock_pin_oe_n = !port_reg[DIR_CLK_BIT];
            end
            WM_TWO, WM_TWO_HOLD: begin
                // open drain: drive only when pulling low
                data_out_pin_oe_n = !(port_reg[DIR_DATA_BIT] && data_low);
                serial_clock_pin_oe_n = !(port_reg[DIR_CLK_BIT] && clk_low);
            end
        endcase
    end

    // interrupts and wake, combinational so enable acts at once
    assign start_irq = start_reg && ctrl_reg[START_IE_BIT] && port_reg[GIE_BIT];
    assign overflow_irq = ovf_reg && ctrl_reg[OVF_IE_BIT] && port_reg[GIE_BIT];
    assign wake_request = start_irq
        || (overflow_irq && sleep_mode == SLEEP_IDLE);

    a_ovf_on_wrap: assert property (@(posedge clk) disable iff (!nrst)
        (wrap |=> ovf_reg)) else $error("overflow flag not set on wrap");
    a_write_wins: assert property (@(posedge clk) disable iff (!nrst)
        (wr_data |=> data_reg == $past(wb_dat_i[7:0]))) else $error("write lost");
    a_shift_left: assert property (@(posedge clk) disable iff (!nrst)
        (shift_clk && !wr_data |=> data_reg[7:1] == $past(data_reg[6:0])))
        else $error("shift wrong");
    a_count_edge: assert property (@(posedge clk) disable iff (!nrst)
        (ext_src && scl_edge && !wr_stat |=> cnt_reg == $past(cnt_reg) + 4'h1))
        else $error("edge not counted");
    a_stop_flag: assert property (@(posedge clk) disable iff (!nrst)
        (stop_cond |=> stop_reg)) else $error("stop missed");
    a_start_flag: assert property (@(posedge clk) disable iff (!nrst)
        (start_cond |=> start_reg)) else $error("start missed");
    a_buf_clear: assert property (@(posedge clk) disable iff (!nrst)
        (rd_buf && !wrap |=> !ovf_reg)) else $error("buffer read kept flag");
    sequence s_ovf_held;
        ovf_reg && wm == WM_TWO_HOLD && port_reg[DIR_CLK_BIT];
    endsequence
    a_hold_clock: assert property (@(posedge clk) disable iff (!nrst)
        (s_ovf_held |-> !serial_clock_pin_oe_n)) else $error("clock not held");
    a_ack_once: assert property (@(posedge clk) disable iff (!nrst)
        (wb_ack_o |=> !wb_ack_o)) else $error("ack too long");
endmodule

// file: verilog/serial_unit_pkg.sv
package serial_unit_pkg;
    // register indices (printed offsets are not multiples of four)
    localparam logic [7:0] CTRL_INDEX = 8'h0D;
    localparam logic [7:0] STAT_INDEX = 8'h0E;
    localparam logic [7:0] DATA_INDEX = 8'h0F;
    localparam logic [7:0] BUF_INDEX = 8'h10;
    localparam logic [7:0] PORT_INDEX = 8'h11;
    // control field positions
    localparam int START_IE_BIT = 7;
    localparam int OVF_IE_BIT = 6;
    localparam int WM_HI_BIT = 5;
    localparam int WM_LO_BIT = 4;
    localparam int CS_HI_BIT = 3;
    localparam int CS_LO_BIT = 2;
    localparam int SHIFT_STB_BIT = 1;
    localparam int TOGGLE_STB_BIT = 0;
    // status field positions
    localparam int START_FLAG_BIT = 7;
    localparam int OVF_FLAG_BIT = 6;
    localparam int STOP_FLAG_BIT = 5;
    localparam int COLL_BIT = 4;
    // port register bits
    localparam int PORT_DATA_BIT = 0;
    localparam int PORT_CLK_BIT = 1;
    localparam int DIR_DATA_BIT = 2;
    localparam int DIR_CLK_BIT = 3;
    localparam int GIE_BIT = 4;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    // wire modes
    localparam logic [1:0] WM_OFF = 2'h0;
    localparam logic [1:0] WM_THREE = 2'h1;
    localparam logic [1:0] WM_TWO = 2'h2;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;
    // clock sources
    localparam logic [1:0] CS_SOFT = 2'h0;
    localparam logic [1:0] CS_TIMER = 2'h1;
    localparam logic [1:0] CS_EXT_POS = 2'h2;
    localparam logic [1:0] CS_EXT_NEG = 2'h3;
    // timing: the serial clock may run at most at a quarter of clk
    localparam int CLK_MHZ = 100;
    localparam int SCK_DIVIDER = 4;
    localparam int SCK_MIN_PERIOD_CYC = SCK_DIVIDER;
    // synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage
